// ---- verilog/rx_dispatch_pkg.sv ----
// rx_dispatch_pkg: codes, descriptor layout and carrier structs for the
// receive channel descriptor dispatch block.
// assumes: one core clock domain; shared by the top and its output buffer.
package rx_dispatch_pkg;

  // adaptation type codes (four bits)
  typedef enum logic [3:0] {
    ADAPT_RAW      = 4'h0,
    ADAPT_RAW_EDROP = 4'h1,
    ADAPT_AAL5     = 4'h5,
    ADAPT_AAL5_54  = 4'h6,
    ADAPT_PACKET   = 4'h7
  } adapt_t;

  // post-processing modes (two bits)
  typedef enum logic [1:0] {
    PP_NORMAL   = 2'h0,
    PP_ROUTED   = 2'h1,
    PP_SCATTER  = 2'h2,
    PP_RESERVED = 2'h3
  } pp_mode_t;

  // per-channel reassembly state
  typedef enum logic [1:0] {
    ST_DOWN  = 2'h0,
    ST_IDLE  = 2'h1,
    ST_REASM = 2'h2,
    ST_ERROR = 2'h3
  } reasm_state_t;

  // kind of arrival presented for a channel
  typedef enum logic [1:0] {
    ARR_CELL = 2'h0,   // data unit that does not end a packet
    ARR_LAST = 2'h1,   // data unit that ends a packet
    ARR_DROP = 2'h2,   // unit lost for lack of resources
    ARR_NONE = 2'h3    // spare, treated as a plain cell
  } arrival_t;

  // packed descriptor word, most significant field first
  typedef struct packed {
    logic [3:0] adaptCode;     // adaptation_type_code
    logic [1:0] post_processing_mode;        // post_processing_mode
    logic [1:0] state;         // reassembly state
    logic       resvd;         // written zero by software
    logic       rtoTest;       // timeout test-and-set, unused here
    logic       reassembly_timeout_enable;     // reassembly_timeout_enable
    logic [2:0] miscFlags;     // per-type flag bits, unused here
    logic [1:0] cutSel;        // cut_through_selector
    logic [3:0] eventQueue;    // event_queue_number
    logic [3:0] poolSel;       // buffer_pool_selector
    logic [7:0] placeOffset;   // buffer_placement_offset
  } chan_desc_t;

  // field positions inside the descriptor word
  localparam int ADAPT_POS  = 28;
  localparam int PP_POS     = 26;
  localparam int STATE_POS  = 24;
  localparam int CUTSEL_POS = 16;
  localparam int EVQ_POS    = 12;
  localparam int POOL_POS   = 8;
  localparam int OFFS_POS   = 0;

  // a zero placement offset stands for 256 bytes
  localparam logic [8:0] OFFSET_ZERO_BYTES = 9'h100;
  localparam int         CT_FLAG_W         = 4;
  localparam logic [15:0] HDR_THRESH_RESET = 16'h0000;

  // one cut-through configuration entry
  typedef struct packed {
    logic [3:0]           rxQueue;   // queue to take a descriptor from
    logic [3:0]           dmaQueue;  // queue to enqueue it to
    logic [CT_FLAG_W-1:0] flags;     // cut-through flags
  } cut_cfg_t;

  // one arrival presented for dispatch
  typedef struct packed {
    chan_desc_t  desc;       // descriptor word of the channel
    logic [31:0] fwdAddr;    // forward_descriptor_address word
    logic [31:0] chanAddr;   // receiving channel's descriptor address
    arrival_t    kind;
    logic [15:0] byteCount;  // bytes received so far in the packet
  } arrival_req_t;

  // dispatch decision for one arrival
  typedef struct packed {
    logic         accept;       // channel took the arrival
    logic         badDesc;      // unknown type or reserved mode
    logic         errEvent;     // drop or refusal to report
    logic         stateWr;      // newState must be written back
    reasm_state_t newState;
    adapt_t       adapt;
    pp_mode_t     post_processing_mode;
    logic         toHost;       // surface buffer to software
    logic         toScheduler;  // hand buffer to transmit scheduler
    logic         toDma;        // scatter/cut-through path
    logic [31:0]  headerAddr;   // channel address for the header
    logic [3:0]   eventQueue;
    logic [3:0]   poolSel;
    logic [8:0]   placeBytes;
    cut_cfg_t     cut;
    logic         hdrThresh;    // packet header threshold event
    logic         rtoArm;       // timeout processing wanted
  } dispatch_t;

  localparam dispatch_t DISPATCH_RESET = '0;

endpackage

// ---- verilog/dispatch_skid_buf.sv ----
// dispatch_skid_buf: two-entry buffer on the dispatch result path.
// assumes: core clock, async active-low reset, clock enable freezes all.
`timescale 1ns/100ps
module dispatch_skid_buf (
  // clock, reset, enable
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic                     clkEn,
  // filling side
  input  wire logic                     inValid,
  input  wire rx_dispatch_pkg::dispatch_t inData,
  output logic                          inReady,
  // draining side
  output logic                          outValid,
  output rx_dispatch_pkg::dispatch_t    outData,
  input  wire logic                     outReady
);
  import rx_dispatch_pkg::*;

  dispatch_t headFF_ff;      // entry shown at the output
  dispatch_t spare_ff;       // second entry, fills on a stall
  logic      headValid_ff;
  logic      spareValid_ff;
  logic      ready_ff;       // registered ready, not-full

  // handshake terms
  wire logic push       = inValid & ready_ff;
  wire logic pop        = headValid_ff & outReady;
  wire logic headFree   = ~headValid_ff | pop;
  // next occupancy; head refills from spare first to keep order
  wire logic nxt_headValid  = headFree ? (spareValid_ff | push) : 1'b1;
  wire logic nxt_spareValid = headFree ? 1'b0
                                       : (spareValid_ff | push);

  // head entry; spare always drains ahead of a new word
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      headFF_ff <= DISPATCH_RESET;
    end else if (clkEn && headFree) begin
      headFF_ff <= spareValid_ff ? spare_ff : inData;
    end
  end

  // spare entry catches a word when the receiver stalls
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      spare_ff <= DISPATCH_RESET;
    end else if (clkEn && !headFree && push) begin
      spare_ff <= inData;
    end
  end

  // occupancy flags; ready is registered so it is glitch free
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      headValid_ff  <= 1'b0;
      spareValid_ff <= 1'b0;
      ready_ff      <= 1'b0;
    end else if (clkEn) begin
      headValid_ff  <= nxt_headValid;
      spareValid_ff <= nxt_spareValid;
      ready_ff      <= ~nxt_spareValid;
    end
  end

  assign inReady  = ready_ff;
  assign outValid = headValid_ff;
  assign outData  = headFF_ff;
endmodule // dispatch_skid_buf

// ---- verilog/rx_channel_descriptor_dispatch.sv ----
// rx_channel_descriptor_dispatch: decodes a channel descriptor for each
// arrival, tracks reassembly state and steers the finished buffer.
// assumes: caller fetches the descriptor words and writes newState back
// when stateWr is set; all inputs synchronous to core_clk.
`timescale 1ns/100ps
module rx_channel_descriptor_dispatch (
  // clock, reset, enable
  input  wire logic                        core_clk,
  input  wire logic                        rst_b,
  input  wire logic                        clkEn,
  // arrival request
  input  wire logic                        reqValid,
  input  wire rx_dispatch_pkg::arrival_req_t reqData,
  output logic                             reqReady,
  // configuration bits
  input  wire logic [15:0]                 headerThresh,
  input  wire rx_dispatch_pkg::cut_cfg_t   cutCfg [4],
  input  wire logic                        errQueueRouteEn,
  input  wire logic [3:0]                  errorQueue,
  // dispatch result
  output logic                             resValid,
  output rx_dispatch_pkg::dispatch_t       resData,
  input  wire logic                        resReady
);
  import rx_dispatch_pkg::*;

  // descriptor view of the request, fields in packed order
  wire chan_desc_t   desc      = reqData.desc;
  wire reasm_state_t curState  = reasm_state_t'(desc.state);
  wire arrival_t     kind      = reqData.kind;

  // adaptation type decode
  wire logic isRaw     = (desc.adaptCode == ADAPT_RAW);
  wire logic isRawEd   = (desc.adaptCode == ADAPT_RAW_EDROP);
  wire logic isAal5    = (desc.adaptCode == ADAPT_AAL5) |
                         (desc.adaptCode == ADAPT_AAL5_54);
  wire logic isPacket  = (desc.adaptCode == ADAPT_PACKET);
  wire logic adaptOk   = isRaw | isRawEd | isAal5 | isPacket;
  wire logic cellMode  = isRaw | isRawEd;  // every unit is a buffer

  // post-processing decode; code three may not be used
  wire logic ppNormal  = (desc.post_processing_mode == PP_NORMAL);
  wire logic ppRouted  = (desc.post_processing_mode == PP_ROUTED);
  wire logic ppScatter = (desc.post_processing_mode == PP_SCATTER);
  wire logic ppOk      = ~(desc.post_processing_mode == PP_RESERVED);

  // down channels take nothing until software sets idle
  wire logic chanUp    = (curState != ST_DOWN);
  wire logic badDesc   = ~adaptOk | ~ppOk;
  wire logic accept    = chanUp & ~badDesc;

  // early drop capable types enter error on a lost unit
  wire logic dropTrack = isRawEd | isAal5 | isPacket;
  wire logic isLast    = (kind == ARR_LAST);
  wire logic isDrop    = (kind == ARR_DROP);
  wire logic inError   = (curState == ST_ERROR);

  // next reassembly state, only written when accepted
  reasm_state_t nxt_state;
  always_comb begin
    nxt_state = curState;
    case (kind)
      ARR_LAST: nxt_state = ST_IDLE;           // packet closed
      ARR_DROP: nxt_state = dropTrack ? ST_ERROR : curState;
      ARR_CELL,
      ARR_NONE: begin
        if (inError) begin
          nxt_state = ST_ERROR;                // hold until final unit
        end else if (cellMode) begin
          nxt_state = ST_IDLE;                 // raw has no reassembly
        end else begin
          nxt_state = ST_REASM;
        end
      end
      default:  nxt_state = curState;
    endcase
  end

  // units in error are dropped except the final one, which goes on
  wire logic deliver   = accept & ~isDrop & ~(inError & ~isLast);
  // a buffer is complete at the last unit, or per unit in raw mode
  wire logic complete  = deliver & (isLast | cellMode);

  // normal packet channel: plain surface, no special work
  wire logic toHost    = complete & ppNormal;
  wire logic toSched   = complete & ppRouted;
  wire logic toDma     = complete & ppScatter;

  // header address: own channel, or forward word when routed
  // the forward word's low flag bits are software's to set
  wire logic [31:0] hdrAddr = ppRouted ? reqData.fwdAddr
                                       : reqData.chanAddr;

  // cut-through configuration chosen by the selector
  wire cut_cfg_t selCut = cutCfg[desc.cutSel];

  // error events may be diverted by the receive queue setup
  wire logic errEvent = ~accept | isDrop;
  wire logic [3:0] evq = (errEvent & errQueueRouteEn) ? errorQueue
                                                      : desc.eventQueue;

  // zero offset is the 256 byte case
  wire logic [8:0] placeBytes = (desc.placeOffset == 8'h00)
                                ? OFFSET_ZERO_BYTES
                                : {1'b0, desc.placeOffset};

  // header threshold on packet channels, zero threshold disables
  wire logic hdrHit = accept & isPacket & ~isDrop &
                      (headerThresh != HDR_THRESH_RESET) &
                      (reqData.byteCount >= headerThresh);

  // timeout work only for enabled reassembling AAL5 channels
  wire logic rtoArm = accept & desc.reassembly_timeout_enable & isAal5 &
                      (nxt_state == ST_REASM);

  // assemble the decision record
  dispatch_t dec;
  always_comb begin
    dec             = DISPATCH_RESET;
    dec.accept      = accept;
    dec.badDesc     = badDesc;
    dec.errEvent    = errEvent;
    dec.stateWr     = accept & (nxt_state != curState);
    dec.newState    = accept ? nxt_state : curState;
    dec.adapt       = adapt_t'(desc.adaptCode);
    dec.post_processing_mode      = pp_mode_t'(desc.post_processing_mode);
    dec.toHost      = toHost;
    dec.toScheduler = toSched;
    dec.toDma       = toDma;
    dec.headerAddr  = hdrAddr;
    dec.eventQueue  = evq;
    dec.poolSel     = desc.poolSel;
    dec.placeBytes  = placeBytes;
    dec.cut         = ppScatter ? selCut : '0;
    dec.hdrThresh   = hdrHit;
    dec.rtoArm      = rtoArm;
  end

  // result buffer: a stalled receiver back-pressures reqReady
  dispatch_skid_buf u_buf (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clkEn    (clkEn),
    .inValid  (reqValid),
    .inData   (dec),
    .inReady  (reqReady),
    .outValid (resValid),
    .outData  (resData),
    .outReady (resReady)
  );

  // handshake helpers for the checks
  wire logic push = reqValid & reqReady & clkEn;

  property p_down_refused;
    @(posedge core_clk) disable iff (!rst_b)
    push && curState == ST_DOWN |-> !dec.accept && !dec.stateWr;
  endproperty
  a_down_refused: assert property (p_down_refused)
    else $error("down channel arrival was accepted");

  property p_reserved_mode;
    @(posedge core_clk) disable iff (!rst_b)
    push && desc.post_processing_mode == PP_RESERVED |-> dec.badDesc &&
      !(dec.toHost || dec.toScheduler || dec.toDma);
  endproperty
  a_reserved_mode: assert property (p_reserved_mode)
    else $error("reserved post mode not refused");

  property p_routed_addr;
    @(posedge core_clk) disable iff (!rst_b)
    push && !resValid && desc.post_processing_mode == PP_ROUTED |=>
      resValid && resData.headerAddr == $past(reqData.fwdAddr);
  endproperty
  a_routed_addr: assert property (p_routed_addr)
    else $error("routed header address not forward word");

  property p_normal_addr;
    @(posedge core_clk) disable iff (!rst_b)
    push && !resValid && desc.post_processing_mode == PP_NORMAL |=>
      resData.headerAddr == $past(reqData.chanAddr) &&
      !resData.toScheduler;
  endproperty
  a_normal_addr: assert property (p_normal_addr)
    else $error("normal header address wrong");

  property p_routed_sched;
    @(posedge core_clk) disable iff (!rst_b)
    dec.toScheduler |-> dec.post_processing_mode == PP_ROUTED && !dec.toHost;
  endproperty
  a_routed_sched: assert property (p_routed_sched)
    else $error("scheduler hand-off outside routed mode");

  property p_offset_zero;
    @(posedge core_clk) disable iff (!rst_b)
    push && !resValid && desc.placeOffset == 8'h00 |=>
      resData.placeBytes == 9'h100;
  endproperty
  a_offset_zero: assert property (p_offset_zero)
    else $error("zero offset did not give 256 bytes");

  property p_last_idle;
    @(posedge core_clk) disable iff (!rst_b)
    push && dec.accept && kind == ARR_LAST |-> dec.newState == ST_IDLE;
  endproperty
  a_last_idle: assert property (p_last_idle)
    else $error("final unit did not return channel to idle");

  property p_rto_gate;
    @(posedge core_clk) disable iff (!rst_b)
    dec.rtoArm |-> desc.reassembly_timeout_enable && dec.newState == ST_REASM;
  endproperty
  a_rto_gate: assert property (p_rto_gate)
    else $error("timeout armed while disabled");

  property p_cut_select;
    @(posedge core_clk) disable iff (!rst_b)
    push && !resValid && desc.post_processing_mode == PP_SCATTER |=>
      resData.cut == $past(selCut);
  endproperty
  a_cut_select: assert property (p_cut_select)
    else $error("cut-through entry not taken from selector");

  property p_stall_hold;
    @(posedge core_clk) disable iff (!rst_b)
    resValid && !resReady |=> resValid && $stable(resData);
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("result changed during stall");

  // a low enable must hold every output where it stands
  property p_freeze;
    @(posedge core_clk) disable iff (!rst_b)
    !clkEn |=> $stable(resValid) && $stable(reqReady) && $stable(resData);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while enable was low");

  // main scenarios
  c_routed:  cover property (@(posedge core_clk) disable iff (!rst_b)
                             resValid && resData.toScheduler);
  c_error:   cover property (@(posedge core_clk) disable iff (!rst_b)
                             push && dec.newState == ST_ERROR);
  c_full:    cover property (@(posedge core_clk) disable iff (!rst_b)
                             reqValid && !reqReady);
  c_thresh:  cover property (@(posedge core_clk) disable iff (!rst_b)
                             resValid && resData.hdrThresh);
endmodule // rx_channel_descriptor_dispatch

// ---- test/result_sink_model.sv ----
// result_sink_model: stands for the receiver of dispatch results.
// assumes: one core clock; holds ready low for stallLen cycles after each
// taken result, and indefinitely while holdOff is high.
`timescale 1ns/100ps
module result_sink_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // stall control from the bench
  input  wire logic [3:0] stallLen,
  input  wire logic       holdOff,
  // result handshake
  input  wire logic       resValid,
  output logic            resReady
);
  logic [3:0] gapCnt_ff;  // cycles left before ready again

  // count the pause that follows each taken result
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gapCnt_ff <= 4'h0;
    end else if (resValid && resReady) begin
      gapCnt_ff <= stallLen;
    end else if (gapCnt_ff != 4'h0) begin
      gapCnt_ff <= gapCnt_ff - 4'h1;
    end
  end

  // ready changes only off the sampling edge, never in mid-handshake
  always @(negedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resReady <= 1'b0;
    end else begin
      resReady <= (gapCnt_ff == 4'h0) && !holdOff;
    end
  end
endmodule // result_sink_model

// ---- test/testbench.sv ----
// testbench: drives arrivals into the dispatch block and checks each result
// against a decision worked out here. assumes: results in request order.
`timescale 1ns/100ps
module testbench;
  import rx_dispatch_pkg::*;
  logic core_clk, rst_b, clkEn, reqValid, reqReady, resValid, resReady;
  arrival_req_t reqData;          // offered arrival
  dispatch_t    resData;          // decision seen
  logic [15:0]  headerThresh;     // header event threshold
  cut_cfg_t     cutCfg [4];       // cut-through entries
  logic         errQueueRouteEn;  // errors to the error queue
  logic [3:0]   errorQueue, stallLen;
  logic         holdOff, rtoOn, stallSeen;
  logic [7:0]   offs;             // placement offset used by mk
  int           badCount, numChecks;
  dispatch_t    expQ [$];         // decisions still owed
  logic [3:0]   codes [6] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7};

  rx_channel_descriptor_dispatch rx_channel_descriptor_dispatch_inst (
    .core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
    .reqValid(reqValid), .reqData(reqData), .reqReady(reqReady),
    .headerThresh(headerThresh), .cutCfg(cutCfg),
    .errQueueRouteEn(errQueueRouteEn), .errorQueue(errorQueue),
    .resValid(resValid), .resData(resData), .resReady(resReady));
  result_sink_model result_sink_model_inst (
    .core_clk(core_clk), .rst_b(rst_b), .stallLen(stallLen),
    .holdOff(holdOff), .resValid(resValid), .resReady(resReady));

  // free-running core clock, 5 ns period
  always #2.5 core_clk = ~core_clk;

  // compare and count
  task automatic check(input string what, input logic [127:0] seen, exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one arrival with fixed queue, pool and addresses
  function automatic arrival_req_t mk(logic [3:0] c, logic [1:0] pp, st,
                                      arrival_t k, logic [15:0] bc);
    arrival_req_t r;
    r = '0;  // reserved bits zero
    r.desc.adaptCode = c;
    r.desc.post_processing_mode = pp;
    r.desc.state = st;
    r.desc.reassembly_timeout_enable = rtoOn;
    r.desc.cutSel = bc[1:0];
    r.desc.eventQueue = 4'h9;
    r.desc.poolSel = 4'h3;
    r.desc.placeOffset = offs;
    r.fwdAddr = 32'hA5A5_0003;  // low flag bits set as in a header
    r.chanAddr = 32'h0000_1240;
    r.kind = k;
    r.byteCount = bc;
    return r;
  endfunction

  // decision expected for an arrival under the present settings
  function automatic dispatch_t model(arrival_req_t r);
    dispatch_t e;
    logic [3:0] c;
    logic known, raw, dlv, cpl;
    e = '0;
    c = r.desc.adaptCode;
    known = c inside {4'h0, 4'h1, 4'h5, 4'h6, 4'h7};
    raw = (c <= 4'h1);
    e.accept = r.desc.state != 2'h0 && known && r.desc.post_processing_mode != 2'h3;
    e.badDesc = !known || r.desc.post_processing_mode == 2'h3;
    e.errEvent = !e.accept || r.kind == ARR_DROP;
    if (r.kind == ARR_LAST) e.newState = ST_IDLE;
    else if (r.kind == ARR_DROP)
      e.newState = (c != 4'h0) ? ST_ERROR : reasm_state_t'(r.desc.state);
    else if (r.desc.state == 2'h3) e.newState = ST_ERROR;
    else e.newState = raw ? ST_IDLE : ST_REASM;
    e.stateWr = e.accept && e.newState != r.desc.state;
    dlv = e.accept && r.kind != ARR_DROP
          && !(r.desc.state == 2'h3 && r.kind != ARR_LAST);
    cpl = dlv && (r.kind == ARR_LAST || raw);
    e.toHost = cpl && r.desc.post_processing_mode == 2'h0;
    e.toScheduler = cpl && r.desc.post_processing_mode == 2'h1;
    e.toDma = cpl && r.desc.post_processing_mode == 2'h2;
    e.adapt = adapt_t'(c);
    e.post_processing_mode = pp_mode_t'(r.desc.post_processing_mode);
    e.headerAddr = (r.desc.post_processing_mode == 2'h1) ? r.fwdAddr : r.chanAddr;
    e.eventQueue = (e.errEvent && errQueueRouteEn) ? errorQueue
                                                   : r.desc.eventQueue;
    e.poolSel = r.desc.poolSel;
    e.placeBytes = (r.desc.placeOffset == 8'h00) ? 9'h100
                                                 : {1'b0, r.desc.placeOffset};
    e.cut = (r.desc.post_processing_mode == 2'h2) ? cutCfg[r.desc.cutSel] : '0;
    e.hdrThresh = e.accept && c == 4'h7 && r.kind != ARR_DROP
                  && headerThresh != 16'h0000 && r.byteCount >= headerThresh;
    e.rtoArm = e.accept && r.desc.reassembly_timeout_enable && c inside {4'h5, 4'h6}
               && e.newState == ST_REASM;
    return e;
  endfunction

  // offer one arrival at a falling edge, hold it until taken
  task automatic send(input arrival_req_t r);
    int n;
    n = 0;
    @(negedge core_clk);
    reqData = r;
    reqValid = 1'b1;
    while (!reqReady && n < 200) begin
      stallSeen = 1'b1;
      n++;
      @(negedge core_clk);
    end
    if (!reqReady) badCount++;  // limit ran out, request never taken
    expQ.push_back(model(r));
    @(posedge core_clk);
  endtask

  // stop offering and wait until every owed result has come
  task automatic drain();
    int n;
    n = 0;
    @(negedge core_clk);
    reqValid = 1'b0;
    while (expQ.size() != 0 && n < 200) begin
      n++;
      @(negedge core_clk);
    end
    check("owed results", expQ.size(), 0);
  endtask

  // results are judged at the edge that takes them
  always @(posedge core_clk) begin
    if (rst_b && resValid && resReady) begin
      if (expQ.size() == 0) begin
        check("unasked result", 1, 0);
      end else if (expQ[0].accept) begin
        check("decision", resData, expQ.pop_front());
      end else begin
        check("refusal", {resData.accept, resData.badDesc, resData.errEvent,
              resData.stateWr, resData.toHost, resData.toScheduler,
              resData.toDma, resData.eventQueue}, {expQ[0].accept,
              expQ[0].badDesc, expQ[0].errEvent, expQ[0].stateWr,
              expQ[0].toHost, expQ[0].toScheduler, expQ[0].toDma,
              expQ[0].eventQueue});
        void'(expQ.pop_front());
      end
    end
  end

  // verdict, reached from the tests or the watchdog
  task automatic conclude();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog: the tests need well under 4000 cycles
  initial begin
    #100000;
    badCount++;
    conclude();
  end

  // main sequence
  initial begin
    core_clk = 1'b0; rst_b = 1'b0; clkEn = 1'b1; reqValid = 1'b0;
    reqData = '0; headerThresh = 16'h0064; errQueueRouteEn = 1'b0;
    errorQueue = 4'hE; stallLen = 4'h0; holdOff = 1'b0; rtoOn = 1'b0;
    offs = 8'h40; stallSeen = 1'b0; badCount = 0; numChecks = 0;
    for (int i = 0; i < 4; i++) cutCfg[i] = {4'(i + 1), 4'(i + 8), 4'(1 << i)};
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    // every type code against every post mode; selector follows bc
    foreach (codes[c]) for (int p = 0; p < 4; p++) for (int s = 0; s < 4; s++)
      send(mk(codes[c], 2'(p), 2'h1, ARR_LAST, 16'(s)));
    drain();
    // every state against every arrival kind, receiver pausing
    stallLen = 4'h3;
    foreach (codes[c]) for (int t = 0; t < 4; t++) for (int k = 0; k < 4; k++)
      send(mk(codes[c], 2'h0, 2'(t), arrival_t'(k), 16'h0));
    drain();
    stallLen = 4'h0;
    // header threshold boundary and disable
    send(mk(4'h7, 2'h0, 2'h2, ARR_CELL, 16'h0063));
    send(mk(4'h7, 2'h0, 2'h2, ARR_CELL, 16'h0064));
    drain();
    headerThresh = 16'h0000;
    send(mk(4'h7, 2'h0, 2'h2, ARR_CELL, 16'h0200));
    drain();
    // error events moved to the error queue
    errQueueRouteEn = 1'b1;
    send(mk(4'h5, 2'h0, 2'h2, ARR_DROP, 16'h0));
    send(mk(4'h5, 2'h0, 2'h0, ARR_CELL, 16'h0));
    send(mk(4'h5, 2'h0, 2'h1, ARR_CELL, 16'h0));
    drain();
    // offset edge values, timeout enable both ways
    for (int o = 0; o < 3; o++) for (int en = 0; en < 2; en++) begin
      offs = (o == 0) ? 8'h00 : (o == 1) ? 8'h01 : 8'hFF;
      rtoOn = en[0];
      send(mk(4'h6, 2'h0, 2'h1, ARR_CELL, 16'h0));
      drain();
    end
    // raw descriptor word: AAL5 routed, idle, offset 0x10
    send('{desc: chan_desc_t'(32'h5500_9310), fwdAddr: 32'hA5A5_0003,
          chanAddr: 32'h0000_1240, kind: ARR_LAST, byteCount: 16'h0});
    drain();
    // scatter result on an empty buffer, selector two
    send(mk(4'h7, 2'h2, 2'h1, ARR_LAST, 16'h0002));
    drain();
    // receiver stalls: buffer fills, request held, nothing lost
    holdOff = 1'b1;
    stallSeen = 1'b0;
    fork
      for (int i = 0; i < 4; i++) send(mk(4'h0, 2'h0, 2'h1, ARR_CELL, 16'(i)));
      begin
        repeat (4) @(negedge core_clk);
        clkEn = 1'b0;  // frozen while both entries are full
        repeat (3) @(negedge core_clk);
        clkEn = 1'b1;
        repeat (3) @(negedge core_clk);
        holdOff = 1'b0;
      end
    join
    drain();
    check("buffer refused when full", stallSeen, 1'b1);
    conclude();
  end
endmodule // testbench
